// ==== rtl/vrsc_pkg.sv ====
/*
 Shared constants and types for the serial regulator command decoder:
 packet bit positions, register map, field layouts and reset values.
 Assumes a single 10 MHz system clock domain in the users of it.
*/
package vrsc_pkg;

	// Packet length in bit slots, acknowledge slots included
	localparam int PKT_BITS = 27;
	// Slot clocks plus the clock rise that leads into the stop
	localparam int PKT_RISES = PKT_BITS + 1;
	// Bit positions, counted from 1 at the first bit after the start
	localparam int POS_PRE = 1;      // Five preamble bits at 1:5
	localparam int POS_CORE = 6;     // Core domain select
	localparam int POS_NB = 7;       // Northbridge domain select
	localparam int POS_ZERO = 8;     // Fixed zero
	localparam int POS_PS0 = 10;     // Level-0 power state, active low
	localparam int POS_VID_HI = 11;  // VID bits 7:1 at 11:17
	localparam int POS_VID_LO = 19;  // VID bit 0
	localparam int POS_PS1 = 20;     // Level-1 power state, active low
	localparam int POS_TFN = 21;     // Telemetry function bit
	localparam int POS_LL = 22;      // Load-line trim at 22:24
	localparam int POS_OFF = 25;     // Offset trim at 25:26
	localparam logic [4:0] PREAMBLE = 5'h18;

	// Register map, byte addresses
	localparam int AXI_AW = 8;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_CORE = 8'h04;
	localparam logic [7:0] REG_NB = 8'h08;
	localparam logic [7:0] REG_STAT = 8'h0c;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Control register fields and reset value
	localparam int CTRL_TWO_PHASE = 0;
	localparam int CTRL_CORE_TEL = 1;
	localparam int CTRL_NB_TEL = 2;
	localparam logic [2:0] CTRL_RESET = 3'h7;

	// Domain state register fields
	localparam int ST_VID = 0;
	localparam int ST_PS0 = 8;
	localparam int ST_PS1 = 9;
	localparam int ST_LL = 10;
	localparam int ST_OFF = 13;
	localparam int ST_TM = 15;

	// Domain settings after reset
	localparam logic [7:0] RST_VID = 8'h00;
	localparam logic RST_PS = 1'b1;
	localparam logic [2:0] RST_LL = 3'h3;
	localparam logic [1:0] RST_OFF = 2'h2;
	localparam logic [7:0] OFFSET_STEP_MV = 8'h19;

	// Current monitor full scale in mV, taken as full load
	localparam logic [17:0] CURRENT_MONITOR_PIN_FULL_MV = 18'h004b0;
	localparam logic [17:0] PCT_FULL = 18'h00064;
	localparam int TEL_FRAME_BITS = 32;

	// Telemetry reporting modes
	typedef enum logic [1:0] {TM_VOLT_CURR, TM_VOLT_ONLY, TM_OFF} vrsc_tm_t;
	localparam vrsc_tm_t RST_TM = TM_VOLT_CURR;

	// Receiver states
	typedef enum logic {RX_IDLE, RX_FRAME} vrsc_rx_t;

endpackage

// ==== rtl/vrsc_telem_tx.sv ====
/*
 Telemetry frame shifter: sends one word, MSB first, one bit per
 falling edge of the command clock between packets, while telemetry is active.
 Assumes shift_tick is a one-cycle pulse already in the clock domain.
*/
`timescale 1ns/10ps
module vrsc_telem_tx
	import vrsc_pkg::*;
(
	input  wire logic                      clock,
	input  wire logic                      reset,
	input  wire logic                      shift_tick,
	input  wire logic                      active,
	input  wire logic [TEL_FRAME_BITS-1:0] frame,
	output logic                           serial_telemetry_out
);
	import vrsc_pkg::*;

	logic [TEL_FRAME_BITS-1:0]         shreg;   // Bits still to send
	logic [$clog2(TEL_FRAME_BITS)-1:0] bit_cnt; // Position in frame

	// Frame is sampled at its first bit so it never tears mid-word
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			shreg <= '0;
			bit_cnt <= '0;
			serial_telemetry_out <= 1'b0;
		end
		else if (shift_tick)
		begin
			if (!active)
			begin
				// Idle low, restart at the next frame boundary
				bit_cnt <= '0;
				serial_telemetry_out <= 1'b0;
			end
			else if (bit_cnt == '0)
			begin
				serial_telemetry_out <= frame[TEL_FRAME_BITS-1];
				shreg <= {frame[TEL_FRAME_BITS-2:0], 1'b0};
				bit_cnt <= bit_cnt + 1'b1;
			end
			else
			begin
				serial_telemetry_out <= shreg[TEL_FRAME_BITS-1];
				shreg <= {shreg[TEL_FRAME_BITS-2:0], 1'b0};
				bit_cnt <= bit_cnt + 1'b1;
			end
		end
	end

endmodule

// ==== rtl/vrsc_decoder.sv ====
/*
 Serial regulator command decoder: receives three-byte command packets,
 applies them per domain after the stop, drives power-state controls,
 trims and the telemetry line, and offers an AXI4-Lite register view.
 Assumes command pins are asynchronous and far slower than the clock.
*/
`timescale 1ns/10ps
module vrsc_decoder
	import vrsc_pkg::*;
(
	input  wire logic                clock,
	input  wire logic                reset,
	input  wire logic                serial_cmd_clock,
	input  wire logic                serial_cmd_data,
	output logic                     serial_telemetry_out,
	input  wire logic [10:0]         core_current_monitor_pin,
	input  wire logic [10:0]         nb_current_monitor_pin,
	output logic [7:0]               core_vid,
	output logic [7:0]               nb_vid,
	output logic                     core_voltage_change_on_the_fly,
	output logic                     nb_voltage_change_on_the_fly,
	output logic                     core_ch1_diode_emulation,
	output logic                     core_ch2_tristate,
	output logic                     nb_ch1_diode_emulation,
	output logic [7:0]               core_loadline_pct,
	output logic [7:0]               nb_loadline_pct,
	output logic [7:0]               core_offset_mv,
	output logic [7:0]               nb_offset_mv,
	output logic                     core_resistor_offset_en,
	output logic                     nb_resistor_offset_en,
	input  wire logic [AXI_AW-1:0]   s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	output logic [1:0]               s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	input  wire logic [AXI_AW-1:0]   s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready
);
	import vrsc_pkg::*;

	// Pin synchronisers, bit 1 clock and bit 0 data
	logic [1:0] sync1;       // First stage, read only by sync2
	logic [1:0] sync2;       // Second stage
	logic [1:0] sync3;       // Third stage
	logic [1:0] filt;        // Accepted pin levels
	logic [1:0] filt_prev;   // Levels one cycle earlier

	// Receiver
	vrsc_rx_t               rx_state;   // Inside a frame or not
	logic [PKT_BITS-1:0]    pkt;        // First bit ends at the top
	logic [4:0]             bit_cnt;    // Slots received
	logic                   overrun;    // More slots than a packet
	logic                   apply;      // One-cycle settings strobe
	logic [15:0]            good_cnt;   // Packets accepted
	logic [15:0]            bad_cnt;    // Packets rejected

	// Per-domain settings, index 0 core and 1 northbridge
	logic [1:0][7:0]        dom_vid;
	logic [1:0]             dom_ps0_n;
	logic [1:0]             dom_ps1_n;
	logic [1:0][2:0]        dom_ll;
	logic [1:0][7:0]        dom_ll_pct;
	logic [1:0][1:0]        dom_off;
	logic [1:0][7:0]        dom_off_mv;
	logic [1:0]             dom_res_en;
	logic [1:0]             dom_upd;
	vrsc_tm_t               dom_tm [2];

	// Software control
	logic [2:0]             ctrl;

	// AXI write holding
	logic                   aw_held;
	logic [AXI_AW-1:0]      aw_addr;
	logic                   w_held;
	logic [31:0]            w_data;
	logic [3:0]             w_strb;

	// Pin level changes on the accepted copies
	wire clk_hi = filt[1] & filt_prev[1];
	wire clk_rise = filt[1] & ~filt_prev[1];
	wire clk_fall = ~filt[1] & filt_prev[1];
	wire dat_fall = ~filt[0] & filt_prev[0];
	wire dat_rise = filt[0] & ~filt_prev[0];
	wire start_det = clk_hi & dat_fall;
	wire stop_det = clk_hi & dat_rise;
	wire frame_end = stop_det & (rx_state == RX_FRAME);

	wire [4:0] pkt_pre = pkt[PKT_BITS-POS_PRE -: 5];
	wire [1:0] pkt_sel = {pkt[PKT_BITS-POS_NB], pkt[PKT_BITS-POS_CORE]};
	wire pkt_zero = pkt[PKT_BITS-POS_ZERO];
	wire [7:0] pkt_vid = {pkt[PKT_BITS-POS_VID_HI -: 7],
		pkt[PKT_BITS-POS_VID_LO]};
	wire pkt_ps0_n = pkt[PKT_BITS-POS_PS0];
	wire pkt_ps1_n = pkt[PKT_BITS-POS_PS1];
	wire pkt_tfn = pkt[PKT_BITS-POS_TFN];
	wire [2:0] pkt_ll = pkt[PKT_BITS-POS_LL -: 3];
	wire [1:0] pkt_off = pkt[PKT_BITS-POS_OFF -: 2];
	// reject bad preamble, bad zero, short or long packets
	wire pkt_ok = (pkt_pre == PREAMBLE) && !pkt_zero && !overrun
		&& (bit_cnt == 5'(PKT_RISES));

	// telemetry mode from domain bits, both set is reserved
	wire tm_valid = (pkt_sel != 2'h3);
	vrsc_tm_t pkt_tm;
	assign pkt_tm = pkt_sel[0] ? TM_OFF
		: (pkt_sel[1] ? TM_VOLT_CURR : TM_VOLT_ONLY);

	// slope as percent of the initial slope
	function automatic logic [7:0] ll_pct(input logic [2:0] code);
		case (code)
			3'h0: ll_pct = 8'h00;
			3'h1: ll_pct = 8'h3c;
			3'h2: ll_pct = 8'h50;
			3'h3: ll_pct = 8'h64;
			3'h4: ll_pct = 8'h78;
			3'h5: ll_pct = 8'h8c;
			3'h6: ll_pct = 8'ha0;
			default: ll_pct = 8'hb4;
		endcase
	endfunction

	// data is only ever sampled, acks are left to the bus pull-up
	// Three stages; the filtered copy moves once stages 2 and 3 agree
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			sync1 <= 2'h3;
			sync2 <= 2'h3;
			sync3 <= 2'h3;
			filt <= 2'h3;
			filt_prev <= 2'h3;
		end
		else
		begin
			sync1 <= {serial_cmd_clock, serial_cmd_data};
			sync2 <= sync1;
			sync3 <= sync2;
			filt <= (sync2 & sync3) | (filt & (sync2 | sync3));
			filt_prev <= filt;
		end
	end

	// shift every slot in, acks included, first bit at the top
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			rx_state <= RX_IDLE;
			pkt <= '0;
			bit_cnt <= '0;
			overrun <= 1'b0;
		end
		else if (start_det)
		begin
			// A repeated start simply restarts the packet
			rx_state <= RX_FRAME;
			bit_cnt <= '0;
			overrun <= 1'b0;
		end
		else if (frame_end)
			rx_state <= RX_IDLE;
		else if (clk_rise && rx_state == RX_FRAME)
		begin
			if (bit_cnt < 5'(PKT_BITS))
			begin
				pkt <= {pkt[PKT_BITS-2:0], filt[0]};
				bit_cnt <= bit_cnt + 5'h01;
			end
			// The rise that leads into the stop carries no slot
			else if (bit_cnt == 5'(PKT_BITS))
				bit_cnt <= 5'(PKT_RISES);
			else
				overrun <= 1'b1;
		end
	end

	// settings move only on the second cycle after a closing stop
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			apply <= 1'b0;
			good_cnt <= '0;
			bad_cnt <= '0;
		end
		else
		begin
			apply <= frame_end && pkt_ok;
			if (frame_end && pkt_ok)
				good_cnt <= good_cnt + 16'h0001;
			if (frame_end && !pkt_ok)
				bad_cnt <= bad_cnt + 16'h0001;
		end
	end

	// One copy of the settings per domain
	for (genvar d = 0; d < 2; d++)
	begin : g_dom
		// load fields into each selected domain
		always_ff @(posedge clock or posedge reset)
		begin
			if (reset)
			begin
				dom_vid[d] <= RST_VID;
				dom_ps0_n[d] <= RST_PS;
				dom_ps1_n[d] <= RST_PS;
				dom_ll[d] <= RST_LL;
				dom_ll_pct[d] <= PCT_FULL[7:0]; // Code 3, initial slope
				dom_off[d] <= RST_OFF;
				dom_off_mv[d] <= 8'h00;
				dom_res_en[d] <= 1'b1;
				dom_upd[d] <= 1'b0;
			end
			else
			begin
				dom_upd[d] <= apply && pkt_sel[d];
				if (apply && pkt_sel[d])
				begin
					dom_vid[d] <= pkt_vid;
					dom_ps0_n[d] <= pkt_ps0_n;
					dom_ps1_n[d] <= pkt_ps1_n;
					dom_ll[d] <= pkt_ll;
					dom_ll_pct[d] <= ll_pct(pkt_ll);
					dom_off[d] <= pkt_off;
					// step on top of the resistor offset
					dom_res_en[d] <= (pkt_off != 2'h0);
					dom_off_mv[d] <= (pkt_off == 2'h3) ? OFFSET_STEP_MV
						: ((pkt_off == 2'h1) ? 8'(-OFFSET_STEP_MV)
						: 8'h00);
				end
			end
		end

		// mode changes only with the function bit high
		always_ff @(posedge clock or posedge reset)
		begin
			if (reset)
				dom_tm[d] <= RST_TM;
			else if (apply && pkt_tfn && tm_valid)
				dom_tm[d] <= pkt_tm;
		end
	end

	// Phase and conduction controls from the held power states
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			core_ch1_diode_emulation <= 1'b0;
			core_ch2_tristate <= 1'b0;
			nb_ch1_diode_emulation <= 1'b0;
		end
		else
		begin
			// level 0 alone decides, level 1 is ignored
			core_ch1_diode_emulation <= !dom_ps0_n[0];
			// second phase only exists in two-phase setup
			core_ch2_tristate <= !dom_ps0_n[0] && ctrl[CTRL_TWO_PHASE];
			nb_ch1_diode_emulation <= !dom_ps0_n[1];
		end
	end

	assign core_vid = dom_vid[0];
	assign nb_vid = dom_vid[1];
	assign core_voltage_change_on_the_fly = dom_upd[0];
	assign nb_voltage_change_on_the_fly = dom_upd[1];
	assign core_loadline_pct = dom_ll_pct[0];
	assign nb_loadline_pct = dom_ll_pct[1];
	assign core_offset_mv = dom_off_mv[0];
	assign nb_offset_mv = dom_off_mv[1];
	assign core_resistor_offset_en = dom_res_en[0];
	assign nb_resistor_offset_en = dom_res_en[1];

	// load percent = mV * 100 / 1200; tops out near 170 at 2 V
	wire [17:0] core_load_x = 18'(core_current_monitor_pin) * PCT_FULL;
	wire [17:0] nb_load_x = 18'(nb_current_monitor_pin) * PCT_FULL;
	wire [17:0] core_load_q = core_load_x / CURRENT_MONITOR_PIN_FULL_MV;
	wire [17:0] nb_load_q = nb_load_x / CURRENT_MONITOR_PIN_FULL_MV;

	// software can silence either output on its own
	wire core_tel = ctrl[CTRL_CORE_TEL] && dom_tm[0] != TM_OFF;
	wire nb_tel = ctrl[CTRL_NB_TEL] && dom_tm[1] != TM_OFF;
	wire core_cur = core_tel && dom_tm[0] == TM_VOLT_CURR;
	wire nb_cur = nb_tel && dom_tm[1] == TM_VOLT_CURR;
	wire [31:0] tel_frame = {core_tel ? dom_vid[0] : 8'h00,
		core_cur ? core_load_q[7:0] : 8'h00,
		nb_tel ? dom_vid[1] : 8'h00,
		nb_cur ? nb_load_q[7:0] : 8'h00};

	// one bit per command clock fall while no packet is running
	vrsc_telem_tx u_telem
	(
		.clock                (clock),
		.reset                (reset),
		.shift_tick           (clk_fall && rx_state == RX_IDLE),
		.active               (core_tel || nb_tel),
		.frame                (tel_frame),
		.serial_telemetry_out (serial_telemetry_out)
	);

	// Register read decode
	wire rd_ctrl = (s_axi_araddr == REG_CTRL);
	wire rd_core = (s_axi_araddr == REG_CORE);
	wire rd_nb = (s_axi_araddr == REG_NB);
	wire rd_stat = (s_axi_araddr == REG_STAT);
	wire rd_hit = rd_ctrl | rd_core | rd_nb | rd_stat;
	wire [16:0] core_word = {dom_tm[0], dom_off[0], dom_ll[0],
		dom_ps1_n[0], dom_ps0_n[0], dom_vid[0]};
	wire [16:0] nb_word = {dom_tm[1], dom_off[1], dom_ll[1],
		dom_ps1_n[1], dom_ps0_n[1], dom_vid[1]};
	wire [31:0] rd_word = rd_ctrl ? {29'h0, ctrl}
		: rd_core ? {15'h0, core_word}
		: rd_nb ? {15'h0, nb_word}
		: rd_stat ? {bad_cnt, good_cnt} : 32'h0;

	// Write side: address and data taken in either order
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	wire do_write = aw_held && w_held && !s_axi_bvalid;
	wire wr_ctrl = (aw_addr == REG_CTRL);
	wire wr_hit = wr_ctrl || aw_addr == REG_CORE || aw_addr == REG_NB
		|| aw_addr == REG_STAT;

	// Write channel holding and response
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			aw_held <= 1'b0;
			aw_addr <= '0;
			w_held <= 1'b0;
			w_data <= '0;
			w_strb <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_write)
			begin
				// Read-only words accept and drop; holes answer SLVERR
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Control register, only byte lane 0 carries bits
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
			ctrl <= CTRL_RESET;
		else if (do_write && wr_ctrl && w_strb[0])
			ctrl <= w_data[2:0];
	end

	// Read side: one read outstanding, answered the next cycle
	assign s_axi_arready = !s_axi_rvalid;
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// Checks on the decoder's own behaviour
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	a_apply_after_stop: assert property (
		apply |-> $past(frame_end) && $past(pkt_ok))
		else $error("settings applied without a closing stop");
	a_core_vid_load: assert property (
		apply && pkt_sel[0] |=> core_vid == $past(pkt_vid)
			&& core_voltage_change_on_the_fly)
		else $error("core domain did not take the VID");
	a_nb_vid_load: assert property (
		apply && pkt_sel[1] |=> nb_vid == $past(pkt_vid)
			&& nb_voltage_change_on_the_fly)
		else $error("northbridge domain did not take the VID");
	a_bad_packet_kept: assert property (
		frame_end && !pkt_ok |=> ##1 $stable(dom_vid) && $stable(dom_ll))
		else $error("rejected packet changed settings");
	a_two_phase_drop: assert property (
		!dom_ps0_n[0] && ctrl[CTRL_TWO_PHASE] |=>
			core_ch2_tristate && core_ch1_diode_emulation)
		else $error("two-phase core did not shed channel 2");
	a_level0_priority: assert property (
		dom_ps0_n[0] && !dom_ps1_n[0] |=>
			!core_ch2_tristate && !core_ch1_diode_emulation)
		else $error("core left full conduction with level 0 off");
	a_nb_diode_mode: assert property (
		!dom_ps0_n[1] |=> nb_ch1_diode_emulation)
		else $error("northbridge channel 1 not in diode emulation");
	a_ll_no_change: assert property (
		apply && pkt_sel[0] && pkt_ll == 3'h3 |=> core_loadline_pct == 8'h64)
		else $error("load-line no-change code not at 100 percent");
	a_offset_disable: assert property (
		apply && pkt_sel[1] && pkt_off == 2'h0 |=>
			!nb_resistor_offset_en && nb_offset_mv == 8'h00)
		else $error("offset disable left an offset active");
	a_tfn_clear_hold: assert property (
		apply && !pkt_tfn |=> dom_tm[0] == $past(dom_tm[0]))
		else $error("telemetry mode moved with function bit clear");

	c_core_packet: cover property (apply && pkt_sel == 2'h1);
	c_both_domains: cover property (apply && pkt_sel == 2'h3);
	c_bad_packet: cover property (frame_end && !pkt_ok);
	c_telem_mode: cover property (apply && pkt_tfn && pkt_sel == 2'h2);

endmodule

// ==== sim/vrsc_host_model.sv ====
/*
 Host side of the serial command link: frames packets MSB first.
 Assumes lines idle high through pull-ups; the clock rests high
 between frames except for tick pulses, and each level is held 400 ns.
*/
`timescale 1ns/10ps
module vrsc_host_model
(
	output logic serial_cmd_clock,
	output logic serial_cmd_data
);
	localparam int HALF = 400; // Half link period in ns

	// Both lines released and pulled high at rest
	initial
	begin
		serial_cmd_clock = 1'b1;
		serial_cmd_data = 1'b1;
	end

	// Send n slots of p; a short n gives a truncated frame
	task automatic send(input logic [26:0] p, input int n);
		// Bus free time before the start
		#HALF;
		// start is data falling while clock high
		serial_cmd_data = 1'b0;
		#HALF;
		for (int i = 0; i < n; i++)
		begin
			serial_cmd_clock = 1'b0;
			#(HALF / 2);
			serial_cmd_data = p[26 - i];
			#(HALF / 2);
			serial_cmd_clock = 1'b1;
			#HALF;
		end
		// stop is data rising while clock high
		serial_cmd_clock = 1'b0;
		#(HALF / 2);
		serial_cmd_data = 1'b0;
		#(HALF / 2);
		serial_cmd_clock = 1'b1;
		#HALF;
		serial_cmd_data = 1'b1;
	endtask

	// one free clock pulse outside frames, data left high
	task automatic tick;
		serial_cmd_clock = 1'b0;
		#HALF;
		serial_cmd_clock = 1'b1;
		#HALF;
	endtask
endmodule

// ==== sim/testbench.sv ====
/*
 Self-checking bench: packets through the host model, AXI4-Lite reads
 of the domain state, all compared with an integer model.
 Assumes the package, decoder and host model are compiled first.
*/
`timescale 1ns/10ps
module testbench;
	import vrsc_pkg::*;
	logic        clock = 0;
	logic        reset = 1;
	logic        sck, sda, tel;
	logic [10:0] cim = 0, nim = 0;
	logic [7:0]  cv, nv, cll, nll, cof, nof, awa = 0, ara = 0;
	logic        cpl, npl, cde, ctr, nde, cre, nre;
	logic [31:0] wd = 0, rdt;
	logic        awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
	logic        awr, wr, bv, arr, rv;
	logic [1:0]  br, rr;
	int          n_fail = 0, cmp_count = 0, seed = 70;
	// Model state per domain, 0 core and 1 northbridge
	int          vid[2], p0[2], p1[2], ll[2], of[2], tm, good, bad, tp;

	always #50 clock = ~clock;

	vrsc_host_model host (.serial_cmd_clock(sck), .serial_cmd_data(sda));

	vrsc_decoder uut (.clock(clock), .reset(reset),
		.serial_cmd_clock(sck), .serial_cmd_data(sda),
		.serial_telemetry_out(tel), .core_current_monitor_pin(cim),
		.nb_current_monitor_pin(nim), .core_vid(cv), .nb_vid(nv),
		.core_voltage_change_on_the_fly(cpl),
		.nb_voltage_change_on_the_fly(npl),
		.core_ch1_diode_emulation(cde), .core_ch2_tristate(ctr),
		.nb_ch1_diode_emulation(nde), .core_loadline_pct(cll),
		.nb_loadline_pct(nll), .core_offset_mv(cof), .nb_offset_mv(nof),
		.core_resistor_offset_en(cre), .nb_resistor_offset_en(nre),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
		.s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv),
		.s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rdt), .s_axi_rresp(rr),
		.s_axi_rvalid(rv), .s_axi_rready(rre));

	task automatic final_report;
		if (n_fail == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Case equality so an unknown never matches
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_fail++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// One AXI access; each channel released once it is taken
	task automatic axi(input bit w, input logic [7:0] a,
		inout logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge clock);
		awa <= a;
		ara <= a;
		wd <= d;
		awv <= w;
		wv <= w;
		arv <= !w;
		bre <= w;
		rre <= !w;
		for (n = 0; n < 100; n++)
		begin
			@(posedge clock);
			if (awv && awr)
				awv <= 1'b0;
			if (wv && wr)
				wv <= 1'b0;
			if (arv && arr)
				arv <= 1'b0;
			if (w ? bv : rv)
				break;
		end
		r = w ? br : rr;
		if (!w)
			d = rdt;
		bre <= 1'b0;
		rre <= 1'b0;
		if (n == 100)
		begin
			n_fail++;
			final_report;
		end
	endtask

	// one whole telemetry frame over 32 free clock pulses
	task automatic telem;
		logic [31:0] s;
		int          e;
		s = 0;
		e = tm == 2 ? 0 : vid[0] << 24 | vid[1] << 8;
		if (tm == 0)
			e = e | (cim * 100 / 1200) << 16 | nim * 100 / 1200;
		for (int j = 0; j < 32; j++)
		begin
			host.tick();
			s = {s[30:0], tel};
		end
		chk(s, e);
	endtask

	function automatic logic [7:0] ofs(input int c);
		return c == 1 ? 8'he7 : c == 3 ? 8'h19 : 8'h00;
	endfunction

	// Compare every domain output but the on-the-fly pulses, and each state register, with the model
	task automatic audit;
		logic [31:0] d;
		logic [1:0]  r;
		int          e;
		for (int i = 0; i < 2; i++)
		begin
			e = tm << 15 | of[i] << 13 | ll[i] << 10 | p1[i] << 9;
			axi(0, i ? REG_NB : REG_CORE, d, r);
			chk(d, e | p0[i] << 8 | vid[i]);
		end
		chk(cv, vid[0]);
		chk(nv, vid[1]);
		chk(cde, p0[0] == 0);
		chk(ctr, p0[0] == 0 && tp);
		chk(nde, p0[1] == 0);
		chk(cll, ll[0] ? 40 + 20 * ll[0] : 0);
		chk(nll, ll[1] ? 40 + 20 * ll[1] : 0);
		chk(cof, ofs(of[0]));
		chk(nof, ofs(of[1]));
		chk(cre, of[0] != 0);
		chk(nre, of[1] != 0);
		axi(0, REG_STAT, d, r);
		chk(d, bad << 16 | good);
	endtask

	// Send one packet; k 0 good, 1 bad preamble, 2 short, 3 zero bit set
	task automatic go(input logic c, n, a, b, t, input logic [7:0] v,
		input logic [2:0] l, input logic [1:0] o, input int k);
		logic [26:0] p;
		int          w;
		p = {PREAMBLE, c, n, 2'h1, a, v[7:1], 1'b1, v[0], b, t, l, o, 1'b1};
		if (k == 1)
			p[26] = ~p[26];
		if (k == 3)
			p[19] = 1'b1;
		fork
			host.send(p, k == 2 ? 20 : 27);
			begin
				repeat (150) @(posedge clock);
				chk(cv, vid[0]);
			end
		join
		bad += k != 0;
		good += k == 0;
		// Telemetry mode follows the domain bits when asked
		if (k == 0 && t && !(c && n))
			tm = c ? 2 : n ? 0 : 1;
		for (int i = 0; i < 2; i++)
			if (k == 0 && (i ? n : c))
			begin
				vid[i] = v;
				p0[i] = a;
				p1[i] = b;
				ll[i] = l;
				of[i] = o;
			end
		// Settings change is flagged by the on-the-fly pulse
		for (w = 0; w < 40 && k == 0 && (c || n); w++)
		begin
			@(posedge clock);
			if (cpl || npl)
				break;
		end
		chk(w < 40, 1);
		if (w == 40)
			final_report;
		repeat (w == 0 ? 20 : 4) @(posedge clock);
		audit;
	endtask

	initial
	begin
		logic [31:0] d;
		logic [1:0]  r;
		tm = 0;
		good = 0;
		bad = 0;
		tp = 1;
		for (int i = 0; i < 2; i++)
		begin
			vid[i] = 0;
			p0[i] = 1;
			p1[i] = 1;
			ll[i] = 3;
			of[i] = 2;
		end
		repeat (16) @(posedge clock);
		reset <= 1'b0;
		d = $random(seed);
		cim <= d[10:0];
		nim <= d[26:16];
		repeat (5) @(posedge clock);
		audit;
		axi(0, REG_CTRL, d, r);
		chk(d, 7);
		axi(1, 8'h10, d, r);
		chk(r, RESP_SLVERR);
		axi(0, 8'h10, d, r);
		chk(d, 0);
		chk(r, RESP_SLVERR);
		axi(1, REG_CORE, d, r);
		chk(r, RESP_OKAY);
		// Every trim code and power-state pair
		for (int i = 0; i < 8; i++)
			go(1'b1, i[0], i[1], i[2], 1'b0, 8'(8'h80 + i), 3'(i), 2'(i), 0);
		// Every telemetry selection, reserved one last
		for (int i = 0; i < 4; i++)
		begin
			go(i[1], i[0], 1'b1, 1'b1, 1'b1, 8'(i), 3'h4, 2'h1, 0);
			telem;
		end
		d = 6;
		axi(1, REG_CTRL, d, r);
		tp = 0;
		go(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 8'h42, 3'h3, 2'h2, 0);
		for (int k = 1; k < 4; k++)
			go(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 8'h99, 3'h5, 2'h3, k);
		for (int i = 0; i < 10; i++)
		begin
			d = $random(seed);
			go(d[0], d[1], d[2], d[3], d[4], d[15:8], d[18:16], d[20:19], 0);
		end
		final_report;
	end
endmodule
